/* logic/fsr_pkg.sv */
/*
 * Shared constants and types for the volatile first status register block.
 * Assumes a single-bit serial link, sampled in SPI mode 0, with the command byte sent first.
 */
package fsr_pkg;

    // Opcodes that the status register decodes itself.
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_READ_ANY = 8'h65;
    localparam logic [7:0] CMD_WRITE_REG = 8'h01;
    localparam logic [7:0] CMD_WRITE_ANY = 8'h71;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_CLEAR_A = 8'h30;
    localparam logic [7:0] CMD_CLEAR_B = 8'h82;
    localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h75;
    localparam logic [7:0] CMD_PROGRAM_SUSPEND = 8'h85;

    // Register addresses seen by the any-register read and write commands.
    localparam logic [23:0] ADDR_STATUS_NV = 24'h000000;
    localparam logic [23:0] ADDR_STATUS_V = 24'h800000;

    // Field positions inside the status byte.
    localparam int BIT_LOCK = 7;
    localparam int BIT_PROG_ERR = 6;
    localparam int BIT_ERASE_ERR = 5;
    localparam int BIT_BP_HI = 4;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_WEL = 1;
    localparam int BIT_BUSY = 0;

    // Power-up content of the persistent status byte.
    localparam logic [7:0] STATUS_NV_RESET = 8'h00;

    // Frame lengths in whole bytes.
    localparam logic [2:0] LEN_SINGLE = 3'h1;
    localparam logic [2:0] LEN_WRITE_REG = 3'h2;
    localparam logic [2:0] LEN_ADDRESSED = 3'h4;
    localparam logic [2:0] LEN_WRITE_ANY = 3'h5;

    typedef enum logic [1:0] {
        FSR_ARR_PROGRAM = 2'h0,
        FSR_ARR_SECTOR_ERASE = 2'h1,
        FSR_ARR_BULK_ERASE = 2'h2
    } fsr_arr_kind_type;

    // Command as assembled on the link clock; read by the system side only between frames.
    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] data;
        logic [2:0] nbytes;
        logic aligned;
        logic seq;
    } fsr_link_cmd_type;

    typedef struct packed {
        fsr_arr_kind_type kind;
        logic [23:0] addr;
    } fsr_arr_req_type;

endpackage

/* logic/fsr_status_one.sv */
/*
 * Volatile first status register of a serial flash together with its command decode.
 * Assumes an array engine outside that runs program and erase, reports completion, and works out
 * from arr_req_o and active_protect_o whether the target lies in a protected area.
 */
// Operation
// - Return status byte for status reads and for any-register reads at the volatile address
// - Bit 7 mirrors persistent write-lock bit
// - Program failure or protected target sets bit 6
// - Erase failure or protected sector sets bit 5
// - Whole-array erase protect hit sets no flag
// - Clear-status and resets clear both failure flags
// - Register writes leave failure flags unchanged
// - Persistent mode writes both protect copies
// - Volatile mode writes volatile protect bits only
// - Refuse program/erase in protected area
// - Whole-array erase only with protect bits zero
// - Writes, program, erase need latch set
// - Enable sets, disable clears, completed writes clear latch
// - Successful operation clears write-enable latch
// - Latch zero after power-up and resets
// - Busy restricts accepted commands to a few
// - Suspend accepted only during array operation
// - Failure keeps busy until clear-status
// - Busy bit cannot be written
// - Hardware lock ignores status register writes
// - Reset loads busy, latch, errors from defaults
`timescale 1ns/10ps
module fsr_status_one import fsr_pkg::*; #(
    parameter logic [7:0] PROGRAM_CMD = 8'h02,
    parameter logic [7:0] SECTOR_ERASE_CMD = 8'hd8,
    parameter logic [7:0] WHOLE_ARRAY_ERASE_CMD = 8'h60,
    parameter logic [7:0] SOFT_RESET_CMD = 8'hf0,
    parameter logic [7:0] FACTORY_DEFAULTS = STATUS_NV_RESET,
    parameter int NV_WRITE_CYC = 64
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic write_protect_n_i,
    input wire logic protect_volatility_select_i,
    input wire logic area_protected_i,
    input wire logic arr_done_i,
    input wire logic arr_fail_i,
    input wire logic arr_prot_hit_i,
    input wire logic arr_suspended_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    output logic [7:0] volatile_status_one_o,
    output logic [2:0] active_protect_o,
    output logic arr_start_o,
    output fsr_arr_req_type arr_req_o,
    output logic arr_suspend_o,
    output logic arr_reset_o
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_ARRAY = 5'b00100,
        ST_REG = 5'b01000,
        ST_FAIL = 5'b10000
    } fsr_state_type;

    // ---------------- Link clock domain ----------------
    logic [2:0] lnk_bit_ff;
    logic [2:0] lnk_byte_ff;
    logic [6:0] lnk_shift_ff;
    fsr_link_cmd_type lnk_cmd_ff;
    logic miso_ff;
    logic miso_oe_n_ff;
    logic [7:0] snap_ff;
    logic seen_seq_ff;
    logic [7:0] lnk_byte_in;
    logic lnk_read_active;

    assign lnk_byte_in = {lnk_shift_ff, mosi_i};

    // Bit and byte counters restart whenever the select is released.
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            lnk_bit_ff <= 3'h0;
            lnk_byte_ff <= 3'h0;
        end else begin
            lnk_bit_ff <= lnk_bit_ff + 3'h1;
            if (lnk_bit_ff == 3'h7 && lnk_byte_ff != 3'h7) begin
                lnk_byte_ff <= lnk_byte_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge sclk_i) begin
        lnk_shift_ff <= lnk_byte_in[6:0];
    end

    // The command record is not cleared at frame end, so the system side can read it while sclk is quiet.
    // Its sequence bit is the inverse of the system side's last seen value, which cannot move during a frame.
    always_ff @(posedge sclk_i) begin
        lnk_cmd_ff.aligned <= (lnk_bit_ff == 3'h7);
        if (lnk_bit_ff == 3'h0 && lnk_byte_ff == 3'h0) begin
            lnk_cmd_ff.seq <= ~seen_seq_ff;
            lnk_cmd_ff.nbytes <= 3'h0;
        end
        if (lnk_bit_ff == 3'h7) begin
            if (lnk_byte_ff != 3'h7) begin
                lnk_cmd_ff.nbytes <= lnk_byte_ff + 3'h1;
            end
            unique case (lnk_byte_ff)
                3'h0: lnk_cmd_ff.opcode <= lnk_byte_in;
                3'h1: lnk_cmd_ff.addr[23:16] <= lnk_byte_in;
                3'h2: lnk_cmd_ff.addr[15:8] <= lnk_byte_in;
                3'h3: lnk_cmd_ff.addr[7:0] <= lnk_byte_in;
                3'h4: lnk_cmd_ff.data <= lnk_byte_in;
                default: ;
            endcase
        end
    end

    assign lnk_read_active = (lnk_cmd_ff.opcode == CMD_READ_STATUS && lnk_byte_ff >= LEN_SINGLE) ||
                             (lnk_cmd_ff.opcode == CMD_READ_ANY && lnk_byte_ff >= LEN_ADDRESSED &&
                              lnk_cmd_ff.addr == ADDR_STATUS_V);

    // Data leaves on the falling edge so the host samples it on the next rising edge.
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            miso_ff <= 1'b0;
            miso_oe_n_ff <= 1'b1;
        end else if (lnk_read_active) begin
            miso_ff <= snap_ff[~lnk_bit_ff];
            miso_oe_n_ff <= 1'b0;
        end else begin
            miso_ff <= 1'b0;
            miso_oe_n_ff <= 1'b1;
        end
    end

    assign miso_o = miso_ff;
    assign miso_oe_n_o = miso_oe_n_ff;

    // ---------------- System clock domain ----------------
    logic [2:0] cs_sync_ff;
    logic cs_idle_ff;
    logic [2:0] wp_sync_ff;
    logic wp_n_ff;
    fsr_state_type state_ff;
    fsr_arr_kind_type kind_ff;
    logic [15:0] reg_timer_ff;
    logic prog_err_ff;
    logic erase_err_ff;
    logic wel_ff;
    logic [2:0] bp_nv_ff;
    logic [2:0] bp_vol_ff;
    logic lock_persist_ff;
    logic lock_mirror_ff;
    logic [7:0] status_ff;
    logic [2:0] active_bp_ff;
    logic arr_start_ff;
    fsr_arr_req_type arr_req_ff;
    logic arr_suspend_ff;
    logic arr_reset_ff;
    logic frame_end;
    logic cmd_go;
    logic busy;
    logic reg_lock;
    logic [7:0] op;
    logic [2:0] nb;
    logic [7:0] wr_data;
    logic ev_write_enable_cmd;
    logic ev_write_disable_cmd;
    logic ev_clear;
    logic ev_soft;
    logic ev_susp;
    logic ev_reg_nv;
    logic ev_reg_v;
    logic ev_prog;
    logic ev_sector;
    logic ev_bulk;
    logic set_perr;
    logic set_eerr;
    logic arr_ok;
    logic reg_done;
    logic [7:0] nxt_status;

    // Select and write-protect pins pass three flops; a change counts once the last two agree.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cs_sync_ff <= 3'h7;
            cs_idle_ff <= 1'b1;
            wp_sync_ff <= 3'h7;
            wp_n_ff <= 1'b1;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], cs_n_i};
            wp_sync_ff <= {wp_sync_ff[1:0], write_protect_n_i};
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_idle_ff <= cs_sync_ff[2];
            end
            if (wp_sync_ff[1] == wp_sync_ff[2]) begin
                wp_n_ff <= wp_sync_ff[2];
            end
        end
    end

    assign frame_end = !cs_idle_ff && cs_sync_ff[1] && cs_sync_ff[2];
    assign cmd_go = frame_end && lnk_cmd_ff.aligned && (lnk_cmd_ff.seq != seen_seq_ff);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            seen_seq_ff <= 1'b0;
        end else if (frame_end) begin
            seen_seq_ff <= lnk_cmd_ff.seq;
        end
    end

    assign op = lnk_cmd_ff.opcode;
    assign nb = lnk_cmd_ff.nbytes;
    assign busy = (state_ff != ST_IDLE);
    assign wr_data = (op == CMD_WRITE_ANY) ? lnk_cmd_ff.data : lnk_cmd_ff.addr[23:16];
    assign reg_lock = lock_persist_ff && !wp_n_ff;

    always_comb begin
        ev_write_enable_cmd = cmd_go && !busy && op == CMD_WRITE_ENABLE && nb == LEN_SINGLE;
        ev_write_disable_cmd = cmd_go && !busy && op == CMD_WRITE_DISABLE && nb == LEN_SINGLE;
        ev_clear = cmd_go && (op == CMD_CLEAR_A || op == CMD_CLEAR_B) && nb == LEN_SINGLE;
        ev_soft = cmd_go && op == SOFT_RESET_CMD && nb == LEN_SINGLE;
        ev_susp = cmd_go && nb == LEN_SINGLE && state_ff == ST_ARRAY &&
                  ((op == CMD_ERASE_SUSPEND && kind_ff != FSR_ARR_PROGRAM) ||
                   (op == CMD_PROGRAM_SUSPEND && kind_ff == FSR_ARR_PROGRAM));
        ev_reg_nv = cmd_go && !busy && wel_ff && !reg_lock &&
                    ((op == CMD_WRITE_REG && nb >= LEN_WRITE_REG) ||
                     (op == CMD_WRITE_ANY && nb == LEN_WRITE_ANY && lnk_cmd_ff.addr == ADDR_STATUS_NV));
        ev_reg_v = cmd_go && !busy && wel_ff && !reg_lock && protect_volatility_select_i &&
                   op == CMD_WRITE_ANY && nb == LEN_WRITE_ANY && lnk_cmd_ff.addr == ADDR_STATUS_V;
        ev_prog = cmd_go && !busy && wel_ff && op == PROGRAM_CMD && nb >= LEN_ADDRESSED;
        ev_sector = cmd_go && !busy && wel_ff && op == SECTOR_ERASE_CMD && nb == LEN_ADDRESSED;
        ev_bulk = cmd_go && !busy && wel_ff && op == WHOLE_ARRAY_ERASE_CMD && nb == LEN_SINGLE &&
                  active_bp_ff == 3'h0;
    end

    always_comb begin
        set_perr = (state_ff == ST_CHECK && area_protected_i && kind_ff == FSR_ARR_PROGRAM) ||
                   (state_ff == ST_ARRAY && arr_done_i && kind_ff == FSR_ARR_PROGRAM &&
                    (arr_fail_i || arr_prot_hit_i));
        set_eerr = (state_ff == ST_CHECK && area_protected_i && kind_ff == FSR_ARR_SECTOR_ERASE) ||
                   (state_ff == ST_ARRAY && arr_done_i && kind_ff != FSR_ARR_PROGRAM &&
                    (arr_fail_i || (arr_prot_hit_i && kind_ff == FSR_ARR_SECTOR_ERASE)));
        arr_ok = state_ff == ST_ARRAY && arr_done_i && !set_perr && !set_eerr;
        reg_done = state_ff == ST_REG && reg_timer_ff == 16'h0000;
    end

    // Busy state: anything but idle reads as busy.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_ff <= FACTORY_DEFAULTS[BIT_BUSY] ? ST_FAIL : ST_IDLE;
            kind_ff <= FSR_ARR_PROGRAM;
            reg_timer_ff <= 16'h0000;
        end else if (ev_soft) begin
            state_ff <= FACTORY_DEFAULTS[BIT_BUSY] ? ST_FAIL : ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (ev_prog || ev_sector) begin
                        state_ff <= ST_CHECK;
                        kind_ff <= ev_prog ? FSR_ARR_PROGRAM : FSR_ARR_SECTOR_ERASE;
                    end else if (ev_bulk) begin
                        state_ff <= ST_ARRAY;
                        kind_ff <= FSR_ARR_BULK_ERASE;
                    end else if (ev_reg_nv) begin
                        state_ff <= ST_REG;
                        reg_timer_ff <= 16'(NV_WRITE_CYC - 1);
                    end
                end
                ST_CHECK: begin
                    state_ff <= area_protected_i ? ST_FAIL : ST_ARRAY;
                end
                ST_ARRAY: begin
                    if (set_perr || set_eerr) begin
                        state_ff <= ST_FAIL;
                    end else if (arr_done_i || arr_suspended_i) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_REG: begin
                    if (reg_done) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        reg_timer_ff <= reg_timer_ff - 16'h0001;
                    end
                end
                ST_FAIL: begin
                    if (ev_clear) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Failure flags: hardware set wins over a clear in the same cycle; register writes never touch them.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || ev_soft) begin
            prog_err_ff <= FACTORY_DEFAULTS[BIT_PROG_ERR];
            erase_err_ff <= FACTORY_DEFAULTS[BIT_ERASE_ERR];
        end else begin
            if (set_perr) begin
                prog_err_ff <= 1'b1;
            end else if (ev_clear) begin
                prog_err_ff <= 1'b0;
            end
            if (set_eerr) begin
                erase_err_ff <= 1'b1;
            end else if (ev_clear) begin
                erase_err_ff <= 1'b0;
            end
        end
    end

    // Write-enable latch.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || ev_soft) begin
            wel_ff <= FACTORY_DEFAULTS[BIT_WEL];
        end else if (ev_write_enable_cmd) begin
            wel_ff <= 1'b1;
        end else if (ev_write_disable_cmd || arr_ok || reg_done || ev_reg_v) begin
            wel_ff <= 1'b0;
        end
    end

    // Protection bits and the write lock; the persistent copies survive a soft reset.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            bp_nv_ff <= STATUS_NV_RESET[BIT_BP_HI:BIT_BP_LO];
            bp_vol_ff <= STATUS_NV_RESET[BIT_BP_HI:BIT_BP_LO];
            lock_persist_ff <= STATUS_NV_RESET[BIT_LOCK];
        end else if (ev_soft) begin
            bp_vol_ff <= bp_nv_ff;
        end else if (ev_reg_nv) begin
            lock_persist_ff <= wr_data[BIT_LOCK];
            bp_vol_ff <= wr_data[BIT_BP_HI:BIT_BP_LO];
            if (!protect_volatility_select_i) begin
                bp_nv_ff <= wr_data[BIT_BP_HI:BIT_BP_LO];
            end
        end else if (ev_reg_v) begin
            bp_vol_ff <= wr_data[BIT_BP_HI:BIT_BP_LO];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lock_mirror_ff <= STATUS_NV_RESET[BIT_LOCK];
        end else begin
            lock_mirror_ff <= lock_persist_ff;
        end
    end

    // The busy bit is derived from the state only, so no write can reach it.
    assign nxt_status = {lock_mirror_ff, prog_err_ff, erase_err_ff, bp_vol_ff, wel_ff, busy};

    // The link snapshot only moves while the select is idle, so a read never sees it change mid-byte.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            status_ff <= 8'h00;
            snap_ff <= 8'h00;
            active_bp_ff <= 3'h0;
        end else begin
            status_ff <= nxt_status;
            active_bp_ff <= protect_volatility_select_i ? bp_vol_ff : bp_nv_ff;
            if (cs_idle_ff) begin
                snap_ff <= nxt_status;
            end
        end
    end

    // Array engine requests.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            arr_start_ff <= 1'b0;
            arr_req_ff <= '0;
            arr_suspend_ff <= 1'b0;
            arr_reset_ff <= 1'b0;
        end else begin
            arr_start_ff <= ev_bulk || (state_ff == ST_CHECK && !area_protected_i && !ev_soft);
            arr_suspend_ff <= ev_susp;
            arr_reset_ff <= ev_soft;
            if (ev_prog || ev_sector || ev_bulk) begin
                arr_req_ff.addr <= lnk_cmd_ff.addr;
                arr_req_ff.kind <= ev_prog ? FSR_ARR_PROGRAM :
                                   (ev_sector ? FSR_ARR_SECTOR_ERASE : FSR_ARR_BULK_ERASE);
            end
        end
    end

    assign volatile_status_one_o = status_ff;
    assign active_protect_o = active_bp_ff;
    assign arr_start_o = arr_start_ff;
    assign arr_req_o = arr_req_ff;
    assign arr_suspend_o = arr_suspend_ff;
    assign arr_reset_o = arr_reset_ff;

endmodule

/* sim/fsr_status_one_properties.sv */
/*
 * Concurrent checks on the ports of the first status register block.
 * Assumes it is bound to fsr_status_one and that srst_i is a synchronous reset on clk_sys_i.
 */
`timescale 1ns/10ps
module fsr_status_one_properties import fsr_pkg::*; #(
    parameter int NV_WRITE_CYC = 64
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic area_protected_i,
    input wire logic arr_done_i,
    input wire logic arr_fail_i,
    input wire logic arr_prot_hit_i,
    input wire logic miso_oe_n_o,
    input wire logic [7:0] volatile_status_one_o,
    input wire logic [2:0] active_protect_o,
    input wire logic arr_start_o,
    input wire fsr_arr_req_type arr_req_o,
    input wire logic arr_suspend_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_reset_latch_busy: assert property (
        disable iff (1'b0) srst_i |=> volatile_status_one_o[1:0] == 2'h0)
        else $error("latch or busy not cleared by reset");
    a_bulk_unprotected: assert property (
        (arr_start_o && arr_req_o.kind == FSR_ARR_BULK_ERASE) |-> active_protect_o == 3'h0)
        else $error("whole erase started with protect bits set");
    a_area_refused: assert property (
        (arr_start_o && arr_req_o.kind != FSR_ARR_BULK_ERASE) |-> !$past(area_protected_i))
        else $error("operation started on protected area");
    a_error_holds_busy: assert property (
        (volatile_status_one_o[BIT_PROG_ERR] || volatile_status_one_o[BIT_ERASE_ERR])
        |-> volatile_status_one_o[BIT_BUSY])
        else $error("failure flag without busy");
    a_start_shows_busy: assert property (
        arr_start_o |-> ##[1:3] volatile_status_one_o[BIT_BUSY])
        else $error("busy not shown after start");
    a_idle_no_drive: assert property (
        cs_n_i |-> miso_oe_n_o)
        else $error("serial output driven while deselected");
    a_bulk_no_flag: assert property (
        (arr_done_i && arr_req_o.kind == FSR_ARR_BULK_ERASE && !arr_fail_i)
        |=> !volatile_status_one_o[BIT_ERASE_ERR] [*3])
        else $error("whole erase set erase failure flag");
    a_success_clears: assert property (
        (arr_done_i && !arr_fail_i && !arr_prot_hit_i) |-> ##[1:4] volatile_status_one_o[1:0] == 2'h0)
        else $error("latch or busy left set after success");
    a_erase_fail_flag: assert property (
        (arr_done_i && arr_fail_i && arr_req_o.kind == FSR_ARR_SECTOR_ERASE)
        |-> ##[1:4] volatile_status_one_o[BIT_ERASE_ERR])
        else $error("erase failure flag not set");
    a_suspend_busy: assert property (
        arr_suspend_o |-> volatile_status_one_o[BIT_BUSY])
        else $error("suspend accepted while idle");
endmodule

bind fsr_status_one fsr_status_one_properties #(.NV_WRITE_CYC(NV_WRITE_CYC)) i_fsr_status_one_properties (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .cs_n_i(cs_n_i),
    .area_protected_i(area_protected_i),
    .arr_done_i(arr_done_i),
    .arr_fail_i(arr_fail_i),
    .arr_prot_hit_i(arr_prot_hit_i),
    .miso_oe_n_o(miso_oe_n_o),
    .volatile_status_one_o(volatile_status_one_o),
    .active_protect_o(active_protect_o),
    .arr_start_o(arr_start_o),
    .arr_req_o(arr_req_o),
    .arr_suspend_o(arr_suspend_o)
);

/* sim/fsr_host_model.sv */
/*
 * Host SPI controller model that frames whole-byte commands for the status register block.
 * Assumes mode 0: data changes after the falling link edge and is sampled on the rising one.
 */
`timescale 1ns/10ps
module fsr_host_model (
    input wire logic miso_i,
    input wire logic miso_oe_n_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Sends nb bytes from the top of tx, then clocks one more byte in when rd is set.
    task automatic xfer(input logic [39:0] tx, input int nb, input bit rd, output logic [7:0] rx);
        int nbit;
        nbit = nb * 8 + (rd ? 8 : 0);
        rx = 8'h00;
        #0.7;
        cs_n_o = 1'b0;
        #20;
        for (int i = 0; i < nbit; i++) begin
            mosi_o = (i < nb * 8) ? tx[39 - i] : ~mosi_o;
            #6 sclk_o = 1'b1;
            if (i >= nb * 8) rx = {rx[6:0], (miso_oe_n_i === 1'b0) ? miso_i : 1'bx};
            #6 sclk_o = 1'b0;
        end
        #6 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #40;
    endtask
endmodule

/* sim/fsr_status_one_test.sv */
/*
 * Self-checking testbench for the first status register block.
 * Assumes the host model for the link and drives the array engine side itself.
 */
`timescale 1ns/10ps
module fsr_status_one_test import fsr_pkg::*; ;
    logic clk_sys_i = 1'b0;
    logic srst_i, sclk, cs_n, mosi, wp_n, vol_sel, area_prot, done, fail, hit;
    logic miso, miso_oe_n, start, suspend, rst_pulse;
    logic [7:0] status, rd;
    logic [2:0] prot;
    fsr_arr_req_type req;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_start = 0;
    int n_susp = 0;
    int n_rst = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i) begin
        n_start += (start === 1'b1);
        n_susp += (suspend === 1'b1);
        n_rst += (rst_pulse === 1'b1);
    end

    fsr_status_one #(.NV_WRITE_CYC(4)) i_fsr_status_one (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .write_protect_n_i(wp_n), .protect_volatility_select_i(vol_sel), .area_protected_i(area_prot),
        .arr_done_i(done), .arr_fail_i(fail), .arr_prot_hit_i(hit), .arr_suspended_i(1'b0),
        .miso_o(miso), .miso_oe_n_o(miso_oe_n), .volatile_status_one_o(status), .active_protect_o(prot),
        .arr_start_o(start), .arr_req_o(req), .arr_suspend_o(suspend), .arr_reset_o(rst_pulse));

    fsr_host_model i_fsr_host_model (
        .miso_i(miso), .miso_oe_n_i(miso_oe_n), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input logic [39:0] tx, input int nb);
        logic [7:0] unused;
        i_fsr_host_model.xfer(tx, nb, 1'b0, unused);
        repeat (8) @(negedge clk_sys_i);
    endtask

    task automatic op(input logic [7:0] c);
        cmd({c, 32'h0}, 1);
    endtask

    // Sets the latch first so that the register write is accepted.
    task automatic register_write_cmd(input logic [7:0] d);
        op(CMD_WRITE_ENABLE);
        cmd({CMD_WRITE_REG, d, 24'h0}, 2);
    endtask

    task automatic pulse_done(input logic f, input logic h);
        @(negedge clk_sys_i);
        {done, fail, hit} = {1'b1, f, h};
        @(negedge clk_sys_i);
        {done, fail, hit} = 3'h0;
        repeat (6) @(negedge clk_sys_i);
    endtask

    task automatic t_latch();
        check("status after reset", 8'h00, status);
        cmd({CMD_WRITE_REG, 8'hff, 24'h0}, 2);
        check("write without latch", 8'h00, status);
        op(CMD_WRITE_ENABLE);
        check("latch set", 8'h02, status);
        op(CMD_WRITE_DISABLE);
        check("latch cleared", 8'h00, status);
        register_write_cmd(8'hff);
        check("persistent write", 8'h9c, status);
        i_fsr_host_model.xfer({CMD_READ_STATUS, 32'h0}, 1, 1'b1, rd);
        check("status read", 8'h9c, rd);
        i_fsr_host_model.xfer({CMD_READ_ANY, ADDR_STATUS_V, 8'h0}, 4, 1'b1, rd);
        check("any register read", 8'h9c, rd);
        $display("test latch done");
    endtask

    task automatic t_lock();
        @(negedge clk_sys_i);
        wp_n = 1'b0;
        register_write_cmd(8'h00);
        check("locked write", 8'h9e, status);
        op(CMD_WRITE_DISABLE);
        wp_n = 1'b1;
        register_write_cmd(8'h00);
        check("unlocked write", 8'h00, status);
        vol_sel = 1'b1;
        register_write_cmd(8'h04);
        check("volatile write", 8'h04, status);
        check("volatile in force", 8'h01, {5'h0, prot});
        vol_sel = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("persistent kept", 8'h00, {5'h0, prot});
        vol_sel = 1'b1;
        $display("test lock done");
    endtask

    task automatic t_protect();
        area_prot = 1'b1;
        op(CMD_WRITE_ENABLE);
        cmd({8'h02, 24'h000100, 8'haa}, 5);
        check("refused program", 8'h41, status & 8'h41);
        area_prot = 1'b0;
        op(CMD_CLEAR_A);
        check("flags cleared", 8'h00, status & 8'h61);
        op(CMD_WRITE_DISABLE);
        op(CMD_WRITE_ENABLE);
        op(8'h60);
        check("whole erase refused", 8'h06, status);
        check("no start", 8'h00, n_start[7:0]);
        op(CMD_WRITE_DISABLE);
        $display("test protect done");
    endtask

    task automatic t_erase();
        register_write_cmd(8'h00);
        op(CMD_WRITE_ENABLE);
        op(8'h60);
        check("whole erase running", 8'h03, status);
        pulse_done(1'b0, 1'b1);
        check("whole erase hit", 8'h00, status & 8'h21);
        op(CMD_WRITE_ENABLE);
        cmd({8'hd8, 24'h010000, 8'h0}, 4);
        check("erase address", 8'h01, req.addr[23:16]);
        op(CMD_WRITE_DISABLE);
        check("busy ignores disable", 8'h03, status);
        op(CMD_ERASE_SUSPEND);
        pulse_done(1'b0, 1'b0);
        check("sector erase clean", 8'h00, status);
        op(CMD_PROGRAM_SUSPEND);
        check("suspend count", 8'h01, n_susp[7:0]);
        op(CMD_WRITE_ENABLE);
        cmd({8'hd8, 24'h020000, 8'h0}, 4);
        pulse_done(1'b1, 1'b0);
        check("erase failure", 8'h21, status & 8'h21);
        op(CMD_CLEAR_B);
        check("second clear opcode", 8'h00, status & 8'h61);
        op(CMD_WRITE_DISABLE);
        check("start count", 8'h03, n_start[7:0]);
        $display("test erase done");
    endtask

    task automatic t_soft_reset();
        op(CMD_WRITE_ENABLE);
        op(8'hf0);
        check("soft reset", 8'h00, status);
        check("reset pulse", 8'h01, n_rst[7:0]);
        $display("test soft reset done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys_i);
        n_mismatch++;
        stop_test();
    end

    initial begin
        {srst_i, wp_n, vol_sel, area_prot, done, fail, hit} = 7'b1100000;
        repeat (3) @(negedge clk_sys_i);
        srst_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        t_latch();
        t_lock();
        t_protect();
        t_erase();
        t_soft_reset();
        stop_test();
    end
endmodule
